// ===== dyn_port_model.sv
// Model of external equipment driving the dynamic control port.
// Assumes the bench calls send() from its main sequence; drives at falling edge.
`timescale 1ns/1ps
module dyn_port_model (
  input  wire logic        clk_in,
  output logic      [18:0] port_out,
  output logic             strobe_out
);
  initial begin
    port_out   = 19'h7FFFF;
    strobe_out = 1'b0;
  end

  // Valid index held well past sync and mask, then released
  task automatic send(input logic [18:0] value);
    @(negedge clk_in);
    port_out = value;
    repeat (2) @(negedge clk_in);
    strobe_out = 1'b1;
    repeat (2) @(negedge clk_in);
    strobe_out = 1'b0;
    repeat (4) @(negedge clk_in);
    port_out = ~value;
  endtask
endmodule // dyn_port_model

// ===== port_width_mask.sv
// Masks the synchronised dynamic port down to its configured valid width.
// Assumes its input is already in the clk_in domain.
`timescale 1ns/1ps
module port_width_mask #(
  parameter int W     = 19,
  parameter int LOW_W = 13
) (
  input  wire logic         clk_in,
  input  wire logic         rstn_in,
  input  wire logic [W-1:0] value_in,
  input  wire logic         low_bits_only_option_in,
  output logic      [W-1:0] masked_out
);
  localparam logic [W-1:0] LOW_MASK = W'((64'h1 << LOW_W) - 64'h1);
  wire [W-1:0] mask_sel = low_bits_only_option_in ? LOW_MASK : {W{1'b1}};

  // Elaboration check: low field must fit inside the port
  if (LOW_W < 1 || LOW_W > W) begin : g_bad_low_width
    $error("LOW_W out of range");
  end

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) masked_out <= '0;
    else          masked_out <= value_in & mask_sel;
  end
endmodule // port_width_mask

// ===== seq_select_ctrl.sv
// Sequence start selection, dynamic entry select and execution status word.
// Assumes sequencer progress events arrive as same-clock pulses; port pins are asynchronous.
`timescale 1ns/1ps
module seq_select_ctrl
  import seq_select_pkg::*;
#(
  parameter int PORT_WIDTH = seq_select_pkg::PORT_W,
  parameter int LOW_WIDTH  = seq_select_pkg::LOW_BITS_W
) (
  input  wire logic                               clk_in,
  input  wire logic                               rstn_in,
  input  wire seq_select_pkg::run_mode_t          run_mode_in,
  input  wire logic                               dynamic_mode_enable_cmd_in,
  input  wire logic                               port_input_disable_cmd_in,
  input  wire logic                               low_bits_only_option_in,
  input  wire logic                               start_index_select_cmd_in,
  input  wire logic [seq_select_pkg::IDX_W-1:0]   start_index_in,
  input  wire logic                               segment_select_in,
  input  wire logic [seq_select_pkg::SEG_W-1:0]   segment_in,
  input  wire logic                               dynamic_entry_select_cmd_in,
  input  wire logic [seq_select_pkg::IDX_W-1:0]   dynamic_entry_in,
  input  wire logic [PORT_WIDTH-1:0]              dyn_port_in,
  input  wire logic                               dyn_port_strobe_in,
  input  wire logic                               run_in,
  input  wire logic                               stop_in,
  input  wire logic                               trigger_in,
  input  wire logic                               wait_advance_in,
  input  wire logic                               advance_in,
  input  wire logic                               execution_status_query_in,
  output logic [seq_select_pkg::STATUS_W-1:0]     sequence_execution_status_out,
  output logic                                    status_valid_out,
  output logic [seq_select_pkg::IDX_W-1:0]        start_entry_out,
  output logic [seq_select_pkg::SEG_W-1:0]        active_segment_out,
  output logic                                    entry_switch_out
);
  import seq_select_pkg::*;

  // Elaboration check: port value is used directly as a table index
  if (PORT_WIDTH != IDX_W) begin : g_bad_port_width
    $error("PORT_WIDTH must equal table index width");
  end

  exec_state_t            state_reg, state_next;
  logic [IDX_W-1:0]       start_idx_reg;
  logic [SEG_W-1:0]       segment_reg;
  logic [IDX_W-1:0]       cur_idx_reg;
  logic [PORT_WIDTH-1:0]  port_s1_reg, port_s2_reg;
  logic [2:0]             stb_sync_reg;
  logic [PORT_WIDTH-1:0]  port_masked;
  logic [STATUS_W-1:0]    status_reg;
  logic                   switch_reg;

  // Two-flop synchroniser on the port data, three-flop on the port strobe
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      port_s1_reg  <= '0;
      port_s2_reg  <= '0;
      stb_sync_reg <= '0;
    end else begin
      port_s1_reg  <= dyn_port_in;
      port_s2_reg  <= port_s1_reg;
      stb_sync_reg <= {stb_sync_reg[1:0], dyn_port_strobe_in};
    end
  end

  port_width_mask #(.W(PORT_WIDTH), .LOW_W(LOW_WIDTH)) u_mask (
    .clk_in                  (clk_in),
    .rstn_in                 (rstn_in),
    .value_in                (port_s2_reg),
    .low_bits_only_option_in (low_bits_only_option_in),
    .masked_out              (port_masked)
  );

  // Mask adds a cycle, so the strobe edge is taken after a third stage
  logic stb_d_reg;
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) stb_d_reg <= 1'b0;
    else          stb_d_reg <= stb_sync_reg[2];
  end
  wire port_rise    = stb_sync_reg[2] & ~stb_d_reg;
  wire stopped      = (state_reg == ST_IDLE);
  wire dyn_on       = dynamic_mode_enable_cmd_in;
  wire static_ok    = !dyn_on && stopped;
  wire take_start   = start_index_select_cmd_in && (dyn_on || stopped);
  wire take_seg     = segment_select_in && static_ok;
  wire port_sel     = dyn_on && !port_input_disable_cmd_in && port_rise;
  wire cmd_sel      = dyn_on && dynamic_entry_select_cmd_in;
  wire dyn_sel      = cmd_sel || port_sel;
  // Command wins when both arrive together
  wire [IDX_W-1:0] dyn_idx = cmd_sel ? dynamic_entry_in : IDX_W'(port_masked);
  wire launching    = stopped && run_in;
  // Only the defined run mode codes give a valid status word
  wire status_ok    = (run_mode_in == MODE_ARB) || (run_mode_in == MODE_SEQ) ||
                      (run_mode_in == MODE_SCEN);

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ST_IDLE: if (run_in) state_next = ST_WTRG;
      ST_WTRG: if (stop_in) state_next = ST_IDLE;
               else if (trigger_in) state_next = ST_RUN;
      ST_RUN:  if (stop_in) state_next = ST_IDLE;
               else if (wait_advance_in) state_next = ST_WADV;
      ST_WADV: if (stop_in) state_next = ST_IDLE;
               else if (advance_in) state_next = ST_RUN;
      default: state_next = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) state_reg <= ST_IDLE;
    else          state_reg <= state_next;
  end

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      start_idx_reg <= IDX_RESET;
      segment_reg   <= SEG_RESET;
    end else begin
      if (take_start) start_idx_reg <= start_index_in;
      if (take_seg)   segment_reg   <= segment_in;
    end
  end

  // Entry in execution: start index at launch, dynamic picks while running
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      cur_idx_reg <= IDX_RESET;
      switch_reg  <= 1'b0;
    end else begin
      switch_reg <= 1'b0;
      if (launching) begin
        cur_idx_reg <= take_start ? start_index_in : start_idx_reg;
      end else if (!stopped && dyn_sel) begin
        cur_idx_reg <= dyn_idx;
        switch_reg  <= 1'b1;
      end
    end
  end

  // Status word is a free-running snapshot, the query strobe only gates validity
  wire [1:0] state_code = (state_reg == ST_WTRG) ? EXEC_WAIT_TRG :
                          (state_reg == ST_RUN)  ? EXEC_RUN :
                          (state_reg == ST_WADV) ? EXEC_WAIT_ADV : EXEC_IDLE;
  wire [STATUS_W-1:0] status_next = {{(STATUS_W-RSVD_LSB){1'b0}}, state_code, cur_idx_reg};

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      status_reg       <= '0;
      status_valid_out <= 1'b0;
    end else begin
      status_reg       <= status_next;
      status_valid_out <= execution_status_query_in && status_ok;
    end
  end

  assign sequence_execution_status_out = status_reg;
  assign start_entry_out               = start_idx_reg;
  assign active_segment_out            = segment_reg;
  assign entry_switch_out              = switch_reg;

  a_status_code: assert property (@(posedge clk_in) disable iff (!rstn_in)
    sequence_execution_status_out[STATE_MSB:STATE_LSB] == $past(state_code))
    else $error("status state code mismatch");
  a_status_index: assert property (@(posedge clk_in) disable iff (!rstn_in)
    sequence_execution_status_out[IDX_W-1:0] == $past(cur_idx_reg))
    else $error("status index mismatch");
  a_status_rsvd: assert property (@(posedge clk_in) disable iff (!rstn_in)
    sequence_execution_status_out[STATUS_W-1:RSVD_LSB] == '0)
    else $error("reserved status bits not zero");
  a_status_valid: assert property (@(posedge clk_in) disable iff (!rstn_in)
    status_valid_out == $past(execution_status_query_in && status_ok))
    else $error("status valid flag mismatch");
  a_launch_start: assert property (@(posedge clk_in) disable iff (!rstn_in)
    (launching && !take_start) |=> cur_idx_reg == $past(start_idx_reg))
    else $error("launch did not use start index");
  sequence s_running_sel;
    !stopped && cmd_sel;
  endsequence
  a_dyn_switch: assert property (@(posedge clk_in) disable iff (!rstn_in)
    s_running_sel |=> (cur_idx_reg == $past(dynamic_entry_in)) && entry_switch_out)
    else $error("dynamic command not applied");
  // Port pick applies only when no command competes in the same cycle
  sequence s_port_sel;
    !stopped && port_sel && !cmd_sel;
  endsequence
  a_port_switch: assert property (@(posedge clk_in) disable iff (!rstn_in)
    s_port_sel |=> (cur_idx_reg == $past(port_masked)) && entry_switch_out)
    else $error("port selection not applied");
  a_idle_hold: assert property (@(posedge clk_in) disable iff (!rstn_in)
    (stopped && !launching) |=> $stable(cur_idx_reg))
    else $error("entry index changed while stopped");
  a_static_hold: assert property (@(posedge clk_in) disable iff (!rstn_in)
    (!dyn_on && !stopped && start_index_select_cmd_in) |=> $stable(start_idx_reg))
    else $error("start index changed while running");
  a_hw_disable: assert property (@(posedge clk_in) disable iff (!rstn_in)
    (port_input_disable_cmd_in && !dynamic_entry_select_cmd_in && !launching)
      |=> $stable(cur_idx_reg))
    else $error("port selection taken while disabled");
  a_query_pure: assert property (@(posedge clk_in) disable iff (!rstn_in)
    (execution_status_query_in && stopped && !run_in) |=> $stable(cur_idx_reg))
    else $error("status query altered state");
  a_seg_take: assert property (@(posedge clk_in) disable iff (!rstn_in)
    take_seg |=> segment_reg == $past(segment_in))
    else $error("segment setting not taken while stopped");
  a_seg_static: assert property (@(posedge clk_in) disable iff (!rstn_in)
    (segment_select_in && dyn_on) |=> $stable(segment_reg))
    else $error("segment changed in dynamic mode");
endmodule // seq_select_ctrl

// ===== seq_select_ctrl_test.sv
// Self-checking bench for the sequence start and dynamic select block.
// Assumes the external port model and a 25 MHz clock; inputs change at falling edge.
`timescale 1ns/1ps
module seq_select_ctrl_test;
  import seq_select_pkg::*;
  logic clk_in = 1'b0, rstn_in = 1'b0;
  run_mode_t run_mode_in = MODE_SEQ;
  logic dyn_en = 0, hw_dis = 0, low_only = 1, sidx_cmd = 0, seg_cmd = 0, dsel_cmd = 0;
  logic run_in = 0, stop_in = 0, trigger_in = 0, wadv_in = 0, adv_in = 0, query_in = 0;
  logic [18:0] sidx = 0, seg = 0, dsel = 0, port_val, start_entry, act_seg;
  logic        port_stb, status_valid, switch_pulse, v1;
  logic [31:0] status;
  int          bad_count = 0, n_tests = 0, cycles = 0;

  always #20 clk_in = ~clk_in;

  dyn_port_model u_port (.clk_in(clk_in), .port_out(port_val), .strobe_out(port_stb));

  seq_select_ctrl u_dut (
    .clk_in(clk_in), .rstn_in(rstn_in), .run_mode_in(run_mode_in),
    .dynamic_mode_enable_cmd_in(dyn_en), .port_input_disable_cmd_in(hw_dis),
    .low_bits_only_option_in(low_only), .start_index_select_cmd_in(sidx_cmd),
    .start_index_in(sidx), .segment_select_in(seg_cmd), .segment_in(seg),
    .dynamic_entry_select_cmd_in(dsel_cmd), .dynamic_entry_in(dsel),
    .dyn_port_in(port_val), .dyn_port_strobe_in(port_stb), .run_in(run_in),
    .stop_in(stop_in), .trigger_in(trigger_in), .wait_advance_in(wadv_in),
    .advance_in(adv_in), .execution_status_query_in(query_in),
    .sequence_execution_status_out(status), .status_valid_out(status_valid),
    .start_entry_out(start_entry), .active_segment_out(act_seg),
    .entry_switch_out(switch_pulse));

  task automatic report_and_stop();
    $display("tests %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  always @(posedge clk_in) begin
    cycles++;
    if (cycles == 5000) begin
      bad_count++;
      report_and_stop();
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      bad_count++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // One cycle on, pulses cleared
  task automatic go(input int n = 1);
    repeat (n) begin
      @(negedge clk_in);
      {sidx_cmd, seg_cmd, dsel_cmd, run_in, stop_in} = '0;
      {trigger_in, wadv_in, adv_in, query_in} = '0;
    end
  endtask

  function automatic logic [31:0] st(input logic [1:0] s, input logic [18:0] i);
    return {11'h000, s, i};
  endfunction

  initial begin
    repeat (8) @(negedge clk_in);
    rstn_in = 1'b1;
    go();
    check(status, 32'h0000_0000);
    for (int m = 0; m < 3; m++) begin
      run_mode_in = run_mode_t'(m);
      query_in = 1;
      go();
      v1 = status_valid;
      go();
      check({31'h0, v1 | status_valid}, 32'h1);
    end
    run_mode_in = run_mode_t'(2'h3);
    query_in = 1;
    go();
    check({31'h0, status_valid}, 32'h0);
    run_mode_in = MODE_SEQ;
    sidx = 19'h12345; sidx_cmd = 1; go(2);
    run_in = 1; go(3);
    check(status, st(EXEC_WAIT_TRG, 19'h12345));
    trigger_in = 1; go(3);
    check(status, st(EXEC_RUN, 19'h12345));
    query_in = 1; go(3);
    check(status, st(EXEC_RUN, 19'h12345));
    wadv_in = 1; go(3);
    check(status, st(EXEC_WAIT_ADV, 19'h12345));
    adv_in = 1; go(3);
    sidx = 19'h00055; sidx_cmd = 1; go();
    seg = 19'h00321; seg_cmd = 1; go();
    dsel = 19'h00066; dsel_cmd = 1; go(3);
    check({13'h0, start_entry}, 32'h12345);
    check({13'h0, act_seg}, 32'h0);
    check(status, st(EXEC_RUN, 19'h12345));
    stop_in = 1; go(3);
    check({30'h0, status[20:19]}, {30'h0, EXEC_IDLE});
    seg_cmd = 1; go(3);
    check({13'h0, act_seg}, 32'h00321);
    dyn_en = 1; sidx = 19'h00007; sidx_cmd = 1; go();
    run_in = 1; go();
    trigger_in = 1; go(3);
    check(status, st(EXEC_RUN, 19'h00007));
    dsel = 19'h00ABC; dsel_cmd = 1; go();
    check({31'h0, switch_pulse}, 32'h1);
    go(2);
    check(status, st(EXEC_RUN, 19'h00ABC));
    u_port.send(19'h5ABCD);
    check(status, st(EXEC_RUN, 19'h5ABCD & 19'h01FFF));
    low_only = 0;
    u_port.send(19'h5ABCD);
    check(status, st(EXEC_RUN, 19'h5ABCD));
    hw_dis = 1;
    u_port.send(19'h01111);
    check(status, st(EXEC_RUN, 19'h5ABCD));
    dsel = 19'h00042; dsel_cmd = 1; go(3);
    check(status, st(EXEC_RUN, 19'h00042));
    report_and_stop();
  end
endmodule // seq_select_ctrl_test

// ===== seq_select_pkg.sv
// Package for the sequence start and dynamic select block.
// Assumes a single 25 MHz clock and command strobes from a remote-control front end.
package seq_select_pkg;
  localparam int IDX_W         = 19;
  localparam int STATUS_W      = 32;
  localparam int STATE_LSB     = 19;
  localparam int STATE_MSB     = 20;
  localparam int RSVD_LSB      = 21;
  localparam int PORT_W        = 19;
  localparam int LOW_BITS_W    = 13;
  localparam int SEG_W         = 19;
  localparam logic [IDX_W-1:0] IDX_RESET = 19'h00000;
  localparam logic [SEG_W-1:0] SEG_RESET = 19'h00000;

  // Execution state codes carried in the status word
  localparam logic [1:0] EXEC_IDLE    = 2'h0;
  localparam logic [1:0] EXEC_WAIT_TRG = 2'h1;
  localparam logic [1:0] EXEC_RUN     = 2'h2;
  localparam logic [1:0] EXEC_WAIT_ADV = 2'h3;

  typedef enum logic [1:0] {
    MODE_ARB  = 2'h0,
    MODE_SEQ  = 2'h1,
    MODE_SCEN = 2'h2
  } run_mode_t;

  typedef enum logic [3:0] {
    ST_IDLE = 4'h1,
    ST_WTRG = 4'h2,
    ST_RUN  = 4'h4,
    ST_WADV = 4'h8
  } exec_state_t;
endpackage
